// [logic/bfp_ctrl.sv]
// Gate sequencing and fault supervision for a constant-on-time buck stage
`timescale 1ns/10ps
`default_nettype none
`include "bfp_regs.svh"
module bfp_ctrl
  import bfp_pkg::*;
#(
  parameter int unsigned RESTART_CYC = `BFP_RESTART_MS * `BFP_MS_CYC,
  parameter int unsigned TON_LIMIT_CYC = `BFP_TON_LIMIT_MS * `BFP_MS_CYC
)(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic en,
  input wire logic ramp_cross,
  input wire logic zero_cross,
  input wire logic [15:0] valley_current,
  input wire logic [15:0] vout_sense,
  input wire logic [15:0] vin_sense,
  input wire logic [15:0] die_temp,
  input wire logic [15:0] output_set_strap,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic high_side_switch,
  output logic low_side_switch,
  input wire logic power_good_output_i,
  output logic power_good_output_o,
  output logic power_good_output_oe,
  output logic fault_active
);
  localparam logic [7:0] CODES [0:`BFP_NREG-1] = `BFP_CMD_CODES;
  localparam logic [15:0] PCT [0:7] = `BFP_LIMIT_PCT;
  localparam logic [21:0] FLOOR_LAST =
    22'(`BFP_FLOOR_CYC - `BFP_BBM_CYC - 2);

  // ==========================================================
  // Configuration words
  bfp_word_t cfg_reg [0:`BFP_NREG-1];
  bfp_word_t cfg_next [0:`BFP_NREG-1];
  logic strap_done_reg;
  logic strap_done_next;

  function automatic bfp_word_t rst_val(input int i);
    case (i)
      `BFP_IX_LOOP: rst_val = `BFP_LOOP_SCALE_DEF;
      `BFP_IX_OCLIM: rst_val = `BFP_OC_LIMIT_DEF;
      `BFP_IX_OCCNT: rst_val = `BFP_OC_COUNT_DEF;
      `BFP_IX_RESTART: rst_val = 16'(RESTART_CYC >> `BFP_DLY_SHIFT);
      `BFP_IX_TONLIM: rst_val = 16'(TON_LIMIT_CYC >> `BFP_DLY_SHIFT);
      `BFP_IX_VINOV: rst_val = `BFP_VIN_OV_DEF;
      `BFP_IX_VINON: rst_val = `BFP_INPUT_TURN_ON_LEVEL_DEF;
      `BFP_IX_VINOFF: rst_val = `BFP_INPUT_TURN_OFF_LEVEL_DEF;
      `BFP_IX_OT: rst_val = `BFP_OT_DEF;
      `BFP_IX_ONTIME: rst_val = `BFP_ON_TIME_DEF;
      default: rst_val = 16'h0000;
    endcase
  endfunction

  // Strap is caught on the first edge after reset release
  assign strap_done_next = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < `BFP_NREG; gi++)
    begin : g_cfg
      logic [23:0] scaled;
      always_comb
      begin
        scaled = 24'h000000;
        cfg_next[gi] = cfg_reg[gi];
        if (!strap_done_reg)
        begin
          if (gi < 8)
          begin
            scaled = 24'(output_set_strap) * 24'(PCT[gi]);
            cfg_next[gi] = 16'(scaled / `BFP_PCT_DIV);
          end
          else if (gi == `BFP_IX_TARGET)
            cfg_next[gi] = output_set_strap;
        end
        else if (cmd_wr && cmd_code == CODES[gi])
          cfg_next[gi] = cmd_wdata;
      end
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
          cfg_reg[gi] <= rst_val(gi);
        else
          cfg_reg[gi] <= cfg_next[gi];
      end
    end
  endgenerate

  // ==========================================================
  // Fault detection; Vin and temperature armed from reset, OV once the strap lands, UV and timeout while running
  bfp_state_t state_reg, state_next;
  logic [21:0] cnt_reg, cnt_next, pu_reg, pu_next, since_reg, since_next;
  logic [8:0] oc_reg, oc_next;
  logic vin_uv_reg, vin_uv_next, ss_reg, ss_next, zc_reg, zc_next;
  logic pg_reg, pg_next, hs_reg, hs_next, ls_reg, ls_next;
  logic [6:0] stat_reg, stat_next;
  logic [15:0] rdata_next;
  logic running, ps_mode, us_mode, oc_now, floor_hit, prebias;
  logic ov_f, vin_ov_f, ot_f, uv_f, oc2_f, tm_f, imm_fault, dly_fault;

  assign running = state_reg inside {BFP_HIGH, BFP_GAP_HL, BFP_LOW,
                                     BFP_GAP_LH};
  assign ps_mode = cfg_reg[`BFP_IX_MODE][`BFP_MODE_PS_BIT];
  assign us_mode = cfg_reg[`BFP_IX_MODE][`BFP_MODE_US_BIT];
  // Limits are zero until the strap lands; no false overvoltage flag
  assign ov_f = strap_done_reg &&
                vout_sense > cfg_reg[`BFP_IX_OV];
  assign vin_ov_f = vin_sense > cfg_reg[`BFP_IX_VINOV];
  assign ot_f = die_temp > cfg_reg[`BFP_IX_OT];
  assign uv_f = running && ss_reg &&
                vout_sense < cfg_reg[`BFP_IX_UV];
  assign oc2_f = oc_reg > 9'(cfg_reg[`BFP_IX_OCCNT]);
  assign tm_f = running && !ss_reg &&
                pu_reg >= {cfg_reg[`BFP_IX_TONLIM], 6'b000000};
  assign imm_fault = ov_f || vin_ov_f || vin_uv_reg || ot_f;
  assign dly_fault = oc2_f || uv_f || tm_f;
  assign oc_now = state_reg == BFP_LOW && cnt_reg >= 22'(`BFP_BLANK_CYC) &&
                  valley_current > cfg_reg[`BFP_IX_OCLIM];
  assign floor_hit = us_mode && since_reg >= FLOOR_LAST;
  assign prebias = vout_sense > cfg_reg[`BFP_IX_TARGET];

  always_comb
  begin
    vin_uv_next = vin_uv_reg;
    if (vin_sense < cfg_reg[`BFP_IX_VINOFF])
      vin_uv_next = 1'b1;
    else if (vin_sense > cfg_reg[`BFP_IX_VINON])
      vin_uv_next = 1'b0;
    // Hardware set beats a software clear in the same cycle
    stat_next = stat_reg;
    if (cmd_wr && cmd_code == `BFP_CMD_STATUS)
      stat_next = stat_reg & ~cmd_wdata[6:0];
    stat_next = stat_next | {tm_f, uv_f, oc2_f, ot_f, vin_uv_reg, vin_ov_f,
                             ov_f};
    rdata_next = cmd_rdata;
    if (cmd_rd)
    begin
      rdata_next = {8'h00, power_good_output_i, stat_reg};
      for (int i = 0; i < `BFP_NREG; i++)
        if (cmd_code == CODES[i])
          rdata_next = cfg_reg[i];
    end
  end

  // ==========================================================
  // Switching sequencer
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg + 22'd1;
    case (state_reg)
      BFP_IDLE:
        if (en && !imm_fault && strap_done_reg && !prebias &&
            (ramp_cross || floor_hit))
          state_next = BFP_HIGH;
      BFP_HIGH:
        if (cnt_reg + 22'd1 >= 22'(cfg_reg[`BFP_IX_ONTIME]))
          state_next = BFP_GAP_HL;
      BFP_GAP_HL:
        if (cnt_reg + 22'd1 >= 22'(`BFP_BBM_CYC))
          state_next = BFP_LOW;
      BFP_LOW:
        if (cnt_reg + 22'd1 >= 22'(`BFP_MIN_OFF_CYC) &&
            (ramp_cross || floor_hit) && !oc_now)
          state_next = BFP_GAP_LH;
      BFP_GAP_LH:
        if (cnt_reg + 22'd1 >= 22'(`BFP_BBM_CYC))
          state_next = BFP_HIGH;
      BFP_WAIT:
        if (cnt_reg >= {cfg_reg[`BFP_IX_RESTART], 6'b000000})
          state_next = BFP_IDLE;
      BFP_HOLD:
        if (!en)
          state_next = BFP_IDLE;
      default:
        state_next = BFP_IDLE;
    endcase
    if (running && dly_fault)
      state_next = cfg_reg[`BFP_IX_RESP][0] ? BFP_HOLD : BFP_WAIT;
    else if (running && (imm_fault || !en))
      state_next = BFP_IDLE;
    if (state_next != state_reg)
      cnt_next = 22'd0;
    // Consecutive limited pulses; a clean crossing restarts the count
    oc_next = oc_reg;
    if (!running)
      oc_next = 9'd0;
    else if (state_reg == BFP_LOW && ramp_cross)
      oc_next = oc_now ? oc_reg + 9'd1 : 9'd0;
    since_next = (state_next == BFP_HIGH && state_reg != BFP_HIGH) ?
                 22'd0 : since_reg + 22'd1;
    if (since_reg == 22'h3fffff)
      since_next = since_reg;
    ss_next = running && (ss_reg ||
              vout_sense >= cfg_reg[`BFP_IX_UV]);
    pu_next = (running && !ss_reg) ? pu_reg + 22'd1 : 22'd0;
    zc_next = state_reg == BFP_LOW && (zc_reg || zero_cross);
    hs_next = state_next == BFP_HIGH;
    ls_next = state_next == BFP_LOW && state_reg == BFP_LOW ?
              (!(ps_mode && (zc_reg || zero_cross)) || oc_now) :
              state_next == BFP_LOW;
    pg_next = pg_reg;
    if (!running || ov_f)
      pg_next = 1'b0;
    else if (vout_sense > cfg_reg[`BFP_IX_PG_ON])
      pg_next = 1'b1;
    else if (vout_sense < cfg_reg[`BFP_IX_PG_OFF])
      pg_next = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= BFP_IDLE;
      cnt_reg <= 22'd0;
      pu_reg <= 22'd0;
      since_reg <= 22'd0;
      oc_reg <= 9'd0;
      vin_uv_reg <= 1'b1;
      ss_reg <= 1'b0;
      zc_reg <= 1'b0;
      pg_reg <= 1'b0;
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
      stat_reg <= 7'h00;
      cmd_rdata <= 16'h0000;
      strap_done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pu_reg <= pu_next;
      since_reg <= since_next;
      oc_reg <= oc_next;
      vin_uv_reg <= vin_uv_next;
      ss_reg <= ss_next;
      zc_reg <= zc_next;
      pg_reg <= pg_next;
      hs_reg <= hs_next;
      ls_reg <= ls_next;
      stat_reg <= stat_next;
      cmd_rdata <= rdata_next;
      strap_done_reg <= strap_done_next;
    end
  end

  assign high_side_switch = hs_reg;
  assign low_side_switch = ls_reg;
  // Open drain: pin is only ever pulled low
  assign power_good_output_o = 1'b0;
  assign power_good_output_oe = !pg_reg;
  assign fault_active = state_reg inside {BFP_WAIT, BFP_HOLD};

  // ==========================================================
  // Checks
  logic [15:0] hs_len_reg, hs_len_next;
  assign hs_len_next = hs_reg ? hs_len_reg + 16'd1 : 16'd0;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      hs_len_reg <= 16'd0;
    else
      hs_len_reg <= hs_len_next;
  end

  sequence s_both_off;
    !high_side_switch && !low_side_switch;
  endsequence
  property p_no_overlap;
    @(posedge ref_clk) disable iff (!resetn) !(hs_reg && ls_reg);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("overlap");
  property p_on_width;
    @(posedge ref_clk) disable iff (!resetn)
      $fell(hs_reg) && state_reg == BFP_GAP_HL |->
        hs_len_reg == cfg_reg[`BFP_IX_ONTIME];
  endproperty
  a_on_width: assert property (p_on_width) else $error("width");
  property p_bbm;
    @(posedge ref_clk) disable iff (!resetn)
      $fell(hs_reg) |-> !ls_reg [*2];
  endproperty
  a_bbm: assert property (p_bbm) else $error("no gap");
  property p_enable;
    @(posedge ref_clk) disable iff (!resetn) !en |=> s_both_off;
  endproperty
  a_enable: assert property (p_enable) else $error("switch off en");
  property p_vin_ov;
    @(posedge ref_clk) disable iff (!resetn) vin_ov_f |=> s_both_off;
  endproperty
  a_vin_ov: assert property (p_vin_ov) else $error("vin ov");
  property p_ot;
    @(posedge ref_clk) disable iff (!resetn) ot_f |=> s_both_off;
  endproperty
  a_ot: assert property (p_ot) else $error("ot");
  property p_pg_ov;
    @(posedge ref_clk) disable iff (!resetn) ov_f |=> power_good_output_oe;
  endproperty
  a_pg_ov: assert property (p_pg_ov) else $error("pg in ov");
  property p_oc2;
    @(posedge ref_clk) disable iff (!resetn)
      running && oc2_f |=> fault_active ##0 s_both_off;
  endproperty
  a_oc2: assert property (p_oc2) else $error("oc fault");
  property p_floor;
    @(posedge ref_clk) disable iff (!resetn)
      us_mode && running |-> since_reg < 22'd2000;
  endproperty
  a_floor: assert property (p_floor) else $error("floor");
  property p_prebias;
    @(posedge ref_clk) disable iff (!resetn)
      state_reg == BFP_IDLE && prebias |=> !hs_reg;
  endproperty
  a_prebias: assert property (p_prebias) else $error("prebias");
endmodule
`default_nettype wire

// [pkg/bfp_regs.svh]
// Command codes, field positions, reset values and timing counts
`ifndef BFP_REGS_SVH
`define BFP_REGS_SVH
// ==========================================================
// Configuration indices and command codes
`define BFP_NREG 21
`define BFP_IX_PG_ON 0
`define BFP_IX_PG_OFF 1
`define BFP_IX_OV 2
`define BFP_IX_UV 5
`define BFP_IX_TARGET 8
`define BFP_IX_LOOP 9
`define BFP_IX_OCLIM 10
`define BFP_IX_OCCNT 11
`define BFP_IX_RESTART 12
`define BFP_IX_TONLIM 13
`define BFP_IX_RESP 14
`define BFP_IX_MODE 15
`define BFP_IX_VINOV 16
`define BFP_IX_VINON 17
`define BFP_IX_VINOFF 18
`define BFP_IX_OT 19
`define BFP_IX_ONTIME 20
`define BFP_CMD_STATUS 8'h79
`define BFP_CMD_CODES '{8'h5e, 8'h5f, 8'h40, 8'h42, 8'h43, 8'h44, 8'h26, \
  8'h25, 8'h21, 8'h29, 8'h46, 8'h47, 8'h48, 8'h50, 8'h49, 8'h01, 8'h55, \
  8'h35, 8'h36, 8'h4f, 8'h33}
// Percent of target for the eight strap-derived limits
`define BFP_LIMIT_PCT '{16'h005a, 16'h0055, 16'h0073, 16'h006e, 16'h005a, \
  16'h0050, 16'h005f, 16'h0069}
`define BFP_PCT_DIV 24'h000064
// ==========================================================
// Reset values
`define BFP_LOOP_SCALE_DEF 16'h0001
`define BFP_OC_LIMIT_DEF 16'h0100
`define BFP_OC_COUNT_DEF 16'h0080
`define BFP_VIN_OV_DEF 16'h3a98
`define BFP_INPUT_TURN_ON_LEVEL_DEF 16'h2710
`define BFP_INPUT_TURN_OFF_LEVEL_DEF 16'h2328
`define BFP_OT_DEF 16'h007d
`define BFP_ON_TIME_DEF 16'h0010
`define BFP_MODE_PS_BIT 0
`define BFP_MODE_US_BIT 1
// ==========================================================
// Timing
`define BFP_CLK_PERIOD_NS 25
`define BFP_BBM_CYC 2
`define BFP_MIN_OFF_CYC 4
`define BFP_BLANK_CYC 3
`define BFP_FLOOR_FREQ_KHZ 20
`define BFP_FLOOR_CYC ((1000000 / `BFP_FLOOR_FREQ_KHZ) / `BFP_CLK_PERIOD_NS)
`define BFP_RESTART_MS 20
`define BFP_TON_LIMIT_MS 20
`define BFP_MS_CYC (1000000 / `BFP_CLK_PERIOD_NS)
`define BFP_DLY_SHIFT 6
`endif

// [pkg/bfp_pkg.sv]
// Types shared by the buck protection controller
package bfp_pkg;
  typedef enum logic [2:0] {
    BFP_IDLE, BFP_HIGH, BFP_GAP_HL, BFP_LOW, BFP_GAP_LH, BFP_WAIT, BFP_HOLD
  } bfp_state_t;
  typedef logic [15:0] bfp_word_t;
endpackage

// [verif/bfp_stage_model.sv]
// Behavioural power stage and sense comparators facing the controller
`timescale 1ns/10ps
`default_nettype none
module bfp_stage_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic high_side_switch,
  input wire logic low_side_switch,
  input wire logic ramp_en,
  input wire logic zc_en,
  input wire logic oc_en,
  output logic ramp_cross,
  output logic zero_cross,
  output logic [15:0] valley_current
);
  logic [3:0] off_cnt;
  logic [2:0] low_cnt;
  // ========
  // Ramp crossing every eleven cycles while the high side is off
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      off_cnt <= 4'h0;
      low_cnt <= 3'h0;
      ramp_cross <= 1'b0;
      zero_cross <= 1'b0;
    end
    else
    begin
      off_cnt <= (high_side_switch || off_cnt == 4'ha) ? 4'h0 : off_cnt + 4'h1;
      low_cnt <= low_side_switch ? low_cnt + 3'h1 : 3'h0;
      ramp_cross <= ramp_en && off_cnt == 4'h9;
      zero_cross <= zc_en && low_side_switch && low_cnt == 3'h3;
    end
  end
  // Valley reads low when the low side is not conducting
  assign valley_current = (oc_en && low_side_switch) ? 16'h0200 : 16'h0040;
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking testbench for the buck protection controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bfp_pkg::*;
  localparam int DLY = 640;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic en = 1'b0;
  logic ramp_en = 1'b1;
  logic zc_en = 1'b0;
  logic oc_en = 1'b0;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  bfp_word_t cmd_wdata = 16'h0000;
  bfp_word_t vout = 16'h03b6;
  bfp_word_t vin = 16'h2ee0;
  bfp_word_t temp = 16'h0019;
  bfp_word_t cmd_rdata;
  bfp_word_t valley;
  logic hs, ls, ramp, zc, pg_o, pg_oe, flt, ok;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] code_tab [10] = '{8'h5e, 8'h5f, 8'h40, 8'h44, 8'h46, 8'h47,
    8'h4f, 8'h33, 8'h48, 8'h50};
  bfp_word_t exp_tab [10] = '{16'h0384, 16'h0352, 16'h047e, 16'h0320,
    16'h0100, 16'h0080, 16'h007d, 16'h0010, 16'h000a, 16'h000a};
  bfp_word_t vi_tab [3] = '{16'h3e80, 16'h1f40, 16'h2ee0};
  bfp_word_t t_tab [3] = '{16'h0019, 16'h0019, 16'h0082};
  always #12.5 ref_clk = ~ref_clk;
  bfp_stage_model stage_u (.ref_clk(ref_clk), .resetn(resetn),
    .high_side_switch(hs), .low_side_switch(ls), .ramp_en(ramp_en),
    .zc_en(zc_en), .oc_en(oc_en), .ramp_cross(ramp), .zero_cross(zc),
    .valley_current(valley));
  // Open-drain pin with pull-up
  bfp_ctrl #(.RESTART_CYC(DLY), .TON_LIMIT_CYC(DLY)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .en(en), .ramp_cross(ramp),
    .zero_cross(zc), .valley_current(valley), .vout_sense(vout),
    .vin_sense(vin), .die_temp(temp), .output_set_strap(16'h03e8),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .high_side_switch(hs),
    .low_side_switch(ls), .power_good_output_i(!pg_oe),
    .power_good_output_o(pg_o), .power_good_output_oe(pg_oe),
    .fault_active(flt));
  // ========
  // Checks and bus tasks
  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp_word(input bfp_word_t got, input bfp_word_t exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  function automatic logic cond(input int w);
    case (w)
      0: return hs;
      1: return flt;
      2: return !flt;
      3: return zc && ls;
      4: return !hs && !ls;
      5: return ls;
      6: return !pg_oe;
      8: return ls && !hs;
      9: return flt && !hs && !ls;
      default: return pg_oe;
    endcase
  endfunction
  task automatic wait_c(input int w, input int lim);
    n = 0;
    @(negedge ref_clk);
    while (cond(w) !== 1'b1 && n < lim)
    begin
      n++;
      @(negedge ref_clk);
    end
    cmp_bit(logic'(n < lim), 1'b1);
  endtask
  task automatic run_len(input int w);
    n = 0;
    while (cond(w) === 1'b1 && n < 3000)
    begin
      n++;
      @(negedge ref_clk);
    end
  endtask
  task automatic hold(input int w, input int num);
    ok = 1'b1;
    repeat (num)
    begin
      @(negedge ref_clk);
      if (cond(w) !== 1'b1) ok = 1'b0;
    end
    cmp_bit(ok, 1'b1);
  endtask
  task automatic sense(input bfp_word_t vo, input bfp_word_t vi,
    input bfp_word_t t);
    @(posedge ref_clk);
    vout <= vo;
    vin <= vi;
    temp <= t;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] c, input bfp_word_t d);
    @(posedge ref_clk);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, input bfp_word_t exp);
    @(posedge ref_clk);
    cmd_rd <= 1'b1;
    cmd_code <= c;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    @(negedge ref_clk);
    cmp_word(cmd_rdata, exp);
  endtask
  // ========
  // Hang guard, well above the expected run length
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim;
    end
  end
  // ========
  // Main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++)
      rd(code_tab[i], exp_tab[i]);
    wr(8'h47, 16'h0004);
    rd(8'h47, 16'h0004);
    hold(4, 40);
    @(posedge ref_clk);
    en <= 1'b1;
    wait_c(0, 100);
    run_len(0);
    cmp_word(16'(n), 16'h0010);
    run_len(4);
    cmp_word(16'(n), 16'h0002);
    run_len(5);
    cmp_bit(logic'(n >= 4), 1'b1);
    run_len(4);
    cmp_word(16'(n), 16'h0002);
    cmp_bit(hs, 1'b1);
    wait_c(6, 100);
    rd(8'h79, 16'h0084);
    sense(16'h0348, 16'h2ee0, 16'h0019);
    wait_c(7, 20);
    sense(16'h03b6, 16'h2ee0, 16'h0019);
    wait_c(6, 20);
    sense(16'h04b0, 16'h2ee0, 16'h0019);
    hold(4, 20);
    cmp_bit(pg_oe, 1'b1);
    cmp_bit(pg_o, 1'b0);
    sense(16'h03b6, 16'h2ee0, 16'h0019);
    wait_c(0, 100);
    cmp_bit(flt, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      sense(16'h03b6, vi_tab[i], t_tab[i]);
      hold(4, 30);
      if (i == 1)
        sense(16'h03b6, 16'h251c, 16'h0019);
      hold(4, 30);
      sense(16'h03b6, 16'h2ee0, 16'h0019);
      wait_c(0, 100);
    end
    wr(8'h01, 16'h0001);
    zc_en <= 1'b1;
    wait_c(3, 200);
    @(negedge ref_clk);
    cmp_bit(ls, 1'b0);
    wr(8'h01, 16'h0003);
    zc_en <= 1'b0;
    ramp_en <= 1'b0;
    wait_c(0, 2000);
    run_len(0);
    wait_c(0, 2000);
    wr(8'h01, 16'h0000);
    ramp_en <= 1'b1;
    wait_c(0, 100);
    wait_c(5, 100);
    @(posedge ref_clk);
    oc_en <= 1'b1;
    hold(8, 35);
    wait_c(1, 200);
    rd(8'h79, 16'h001f);
    run_len(9);
    cmp_bit(logic'(n >= DLY - 8 && n <= DLY), 1'b1);
    wait_c(0, 100);
    @(posedge ref_clk);
    oc_en <= 1'b0;
    sense(16'h01f4, 16'h2ee0, 16'h0019);
    wait_c(1, 20);
    sense(16'h03b6, 16'h2ee0, 16'h0019);
    wait_c(2, 700);
    wait_c(0, 100);
    @(posedge ref_clk);
    en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    hold(4, 30);
    sense(16'h044c, 16'h2ee0, 16'h0019);
    en <= 1'b1;
    hold(4, 100);
    wr(8'h49, 16'h0001);
    @(posedge ref_clk);
    en <= 1'b0;
    sense(16'h0000, 16'h2ee0, 16'h0019);
    en <= 1'b1;
    hold(2, 100);
    wait_c(1, 700);
    rd(8'h79, 16'h007f);
    hold(9, 700);
    wr(8'h79, 16'h007f);
    rd(8'h79, 16'h0000);
    @(posedge ref_clk);
    en <= 1'b0;
    wait_c(2, 10);
    end_sim;
  end
endmodule
`default_nettype wire
